/* verilog/ssc_pkg.sv */
package ssc_pkg;
	localparam int N_COMP = 8;
	localparam int P_W    = 16;
	localparam int E_W    = 18;
	localparam int ADC_W  = 12;
	localparam int SPD_W  = 10;
	localparam int RT_W   = 24;
	localparam int A_W    = 8;
	localparam int CLK_HZ       = 200_000_000;
	localparam int CYCLE_TIME_S = 1;
	localparam int CYCLE_CLKS   = CYCLE_TIME_S * CLK_HZ;
	localparam logic [ADC_W-1:0] ADC_ZERO_CUR = 12'h333;
	localparam logic [ADC_W-1:0] ADC_ZERO_VOL = 12'h000;
	localparam logic [15:0]      SCALE_K_CUR  = 16'h1401;
	localparam logic [15:0]      SCALE_K_VOL  = 16'h1001;
	localparam int               SCALE_SH     = 24;
	localparam logic [SPD_W-1:0] SPD_FULL     = 10'h3ff;
	localparam logic [SPD_W-1:0] SPD_HALF     = 10'h200;
	localparam logic [SPD_W-1:0] SPD_I_MAX    = 10'h066;
	localparam logic [SPD_W-1:0] SPD_RAMP     = 10'h0cc;
	localparam logic [SPD_W-1:0] SPD_COMP     = 10'h200;
	localparam logic [7:0]       FREQ_LOW_HZ  = 8'h19;
	localparam logic [7:0]       FREQ_HIGH_HZ = 8'h57;
	localparam logic [A_W-1:0] OFF_CTRL  = 8'h00;
	localparam logic [A_W-1:0] OFF_PMIN  = 8'h04;
	localparam logic [A_W-1:0] OFF_PMAX  = 8'h08;
	localparam logic [A_W-1:0] OFF_SETP  = 8'h0c;
	localparam logic [A_W-1:0] OFF_NZ    = 8'h10;
	localparam logic [A_W-1:0] OFF_ADJ   = 8'h14;
	localparam logic [A_W-1:0] OFF_MINSP = 8'h18;
	localparam logic [A_W-1:0] OFF_BLT   = 8'h1c;
	localparam logic [A_W-1:0] OFF_ROT   = 8'h20;
	localparam logic [A_W-1:0] OFF_STAT  = 8'h24;
	localparam logic [A_W-1:0] OFF_PRESS = 8'h28;
	localparam logic [A_W-1:0] OFF_ERR   = 8'h2c;
	localparam logic [A_W-1:0] OFF_SPEED = 8'h30;
	localparam logic [A_W-1:0] OFF_COMP  = 8'h34;
	localparam int CTRL_COMB = 0;
	localparam int CTRL_VOLT = 1;
	localparam int CTRL_CAP  = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic                    cap;
		logic                    volt;
		logic                    comb;
		logic signed [P_W-1:0]   pmin;
		logic signed [P_W-1:0]   pmax;
		logic signed [P_W-1:0]   setp;
		logic signed [P_W-1:0]   nz;
		logic signed [P_W-1:0]   adj;
		logic [SPD_W-1:0]        min_spd;
		logic [15:0]             bl_time;
		logic [N_COMP-1:0]       rot;
	} ssc_cfg_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_START = 3'b010,
		ST_RUN   = 3'b100
	} ssc_state_t;
endpackage

/* verilog/ssc_ctrl.sv */
module ssc_ctrl #(
	parameter int CYCLE_CLKS = ssc_pkg::CYCLE_CLKS
) (
	input  wire logic                            aclk,        // 200 MHz clock
	input  wire logic                            aresetn,     // Sync reset, active low
	input  wire logic                            ce,          // Clock enable, freezes all state
	input  wire logic [ssc_pkg::A_W-1:0]         awaddr,      // Write address
	input  wire logic [2:0]                      awprot,      // Unused protection
	input  wire logic                            awvalid,     // Write address valid
	output logic                                 awready,     // Write address ready
	input  wire logic [31:0]                     wdata,       // Write data
	input  wire logic [3:0]                      wstrb,       // Byte enables
	input  wire logic                            wvalid,      // Write data valid
	output logic                                 wready,      // Write data ready
	output logic [1:0]                           bresp,       // Write response
	output logic                                 bvalid,      // Write response valid
	input  wire logic                            bready,      // Write response ready
	input  wire logic [ssc_pkg::A_W-1:0]         araddr,      // Read address
	input  wire logic [2:0]                      arprot,      // Unused protection
	input  wire logic                            arvalid,     // Read address valid
	output logic                                 arready,     // Read address ready
	output logic [31:0]                          rdata,       // Read data
	output logic [1:0]                           rresp,       // Read response
	output logic                                 rvalid,      // Read data valid
	input  wire logic                            rready,      // Read data ready
	input  wire logic [ssc_pkg::ADC_W-1:0]       adc_code,    // Transducer A/D code
	output logic [ssc_pkg::N_COMP-1:0]           comp_en,     // Compressor base stage enables
	output logic [ssc_pkg::N_COMP-1:0]           comp_cap_en, // Compressor capacity stage enables
	output logic [ssc_pkg::SPD_W-1:0]            speed_out,   // Speed adjuster level
	output logic                                 sensor_change // Sticky sensor-change event
);
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	localparam int NC = ssc_pkg::N_COMP;
	localparam int SW = ssc_pkg::SPD_W;
	localparam int EW = ssc_pkg::E_W;
	ssc_pkg::ssc_cfg_t cfg_reg, cfg_next;
	logic [ssc_pkg::A_W-1:0] wa_reg, wa_next;
	logic [31:0] wd_reg, wd_next, wm_reg, wm_next, rdat_next;
	logic aw_f_reg, aw_f_next, w_f_reg, w_f_next, bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0] br_reg, br_next, rr_reg, rr_next;
	logic [31:0] rdat_reg;
	logic sc_reg, sc_next, wr_fire, map_hit;
	logic signed [EW-1:0] err_reg, err_next;
	logic signed [ssc_pkg::P_W-1:0] press_reg, press_next, press_now;
	logic [SW-1:0] spd_reg, spd_next;
	logic [7:0] freq_reg, freq_next;
	logic [NC-1:0] en_reg, en_next, cap_reg, cap_next;
	logic [31:0] wval, wold;

	always_comb begin
		wm_next = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
		aw_f_next = aw_f_reg;
		w_f_next  = w_f_reg;
		wa_next   = wa_reg;
		wd_next   = wd_reg;
		if (awvalid && !aw_f_reg) begin
			aw_f_next = 1'b1;
			wa_next   = awaddr;
		end
		if (wvalid && !w_f_reg) begin
			w_f_next = 1'b1;
			wd_next  = wdata;
		end else begin
			wm_next = wm_reg;
		end
		wr_fire = aw_f_reg && w_f_reg && !bv_reg;
		if (wr_fire) begin
			aw_f_next = 1'b0;
			w_f_next  = 1'b0;
		end
		bv_next = wr_fire || (bv_reg && !bready);
		br_next = br_reg;
		map_hit = wa_reg <= ssc_pkg::OFF_STAT;
		if (wr_fire)
			br_next = map_hit ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
		rv_next   = rv_reg && !rready;
		rdat_next = rdat_reg;
		rr_next   = rr_reg;
		if (arvalid && !rv_reg) begin
			rv_next = 1'b1;
			rr_next = ssc_pkg::RESP_OKAY;
			case (araddr)
				ssc_pkg::OFF_CTRL:  rdat_next = 32'({cfg_reg.cap, cfg_reg.volt, cfg_reg.comb});
				ssc_pkg::OFF_PMIN:  rdat_next = 32'($signed(cfg_reg.pmin));
				ssc_pkg::OFF_PMAX:  rdat_next = 32'($signed(cfg_reg.pmax));
				ssc_pkg::OFF_SETP:  rdat_next = 32'($signed(cfg_reg.setp));
				ssc_pkg::OFF_NZ:    rdat_next = 32'($signed(cfg_reg.nz));
				ssc_pkg::OFF_ADJ:   rdat_next = 32'($signed(cfg_reg.adj));
				ssc_pkg::OFF_MINSP: rdat_next = 32'(cfg_reg.min_spd);
				ssc_pkg::OFF_BLT:   rdat_next = 32'(cfg_reg.bl_time);
				ssc_pkg::OFF_ROT:   rdat_next = 32'(cfg_reg.rot);
				ssc_pkg::OFF_STAT:  rdat_next = 32'(sc_reg);
				ssc_pkg::OFF_PRESS: rdat_next = 32'($signed(press_reg));
				ssc_pkg::OFF_ERR:   rdat_next = 32'($signed(err_reg));
				ssc_pkg::OFF_SPEED: rdat_next = {8'h00, freq_reg, 6'h00, spd_reg};
				ssc_pkg::OFF_COMP:  rdat_next = {16'h0000, cap_reg, en_reg};
				default: begin
					rdat_next = 32'h0000_0000;
					rr_next   = ssc_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration and sensor-change event
	// ----------------------------------------------------------------
	always_comb begin
		cfg_next = cfg_reg;
		wold     = 32'h0000_0000;
		case (wa_reg)
			ssc_pkg::OFF_CTRL:  wold = 32'({cfg_reg.cap, cfg_reg.volt, cfg_reg.comb});
			ssc_pkg::OFF_PMIN:  wold = 32'($signed(cfg_reg.pmin));
			ssc_pkg::OFF_PMAX:  wold = 32'($signed(cfg_reg.pmax));
			default:            wold = 32'h0000_0000;
		endcase
		wval    = (wd_reg & wm_reg) | (wold & ~wm_reg);
		sc_next = sc_reg;
		if (wr_fire && wa_reg == ssc_pkg::OFF_STAT && wval[0])
			sc_next = 1'b0;
		if (wr_fire) begin
			case (wa_reg)
				ssc_pkg::OFF_CTRL: begin
					cfg_next.comb = wval[ssc_pkg::CTRL_COMB];
					cfg_next.volt = wval[ssc_pkg::CTRL_VOLT];
					cfg_next.cap  = wval[ssc_pkg::CTRL_CAP];
					if (wval[ssc_pkg::CTRL_VOLT] != cfg_reg.volt)
						sc_next = 1'b1;
				end
				ssc_pkg::OFF_PMIN: begin
					cfg_next.pmin = wval[15:0];
					if (wval[15:0] != cfg_reg.pmin)
						sc_next = 1'b1;
				end
				ssc_pkg::OFF_PMAX: begin
					cfg_next.pmax = wval[15:0];
					if (wval[15:0] != cfg_reg.pmax)
						sc_next = 1'b1;
				end
				ssc_pkg::OFF_SETP:  cfg_next.setp    = wval[15:0];
				ssc_pkg::OFF_NZ:    cfg_next.nz      = wval[15:0];
				ssc_pkg::OFF_ADJ:   cfg_next.adj     = wval[15:0];
				ssc_pkg::OFF_MINSP: cfg_next.min_spd = wval[SW-1:0];
				ssc_pkg::OFF_BLT:   cfg_next.bl_time = wval[15:0];
				ssc_pkg::OFF_ROT:   cfg_next.rot     = wval[NC-1:0];
				default:            cfg_next = cfg_reg;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg  <= '0;
			wa_reg   <= '0;
			wd_reg   <= '0;
			wm_reg   <= '0;
			aw_f_reg <= 1'b0;
			w_f_reg  <= 1'b0;
			bv_reg   <= 1'b0;
			br_reg   <= ssc_pkg::RESP_OKAY;
			rv_reg   <= 1'b0;
			rr_reg   <= ssc_pkg::RESP_OKAY;
			rdat_reg <= '0;
			sc_reg   <= 1'b0;
		end else if (ce) begin
			cfg_reg  <= cfg_next;
			wa_reg   <= wa_next;
			wd_reg   <= wd_next;
			wm_reg   <= wm_next;
			aw_f_reg <= aw_f_next;
			w_f_reg  <= w_f_next;
			bv_reg   <= bv_next;
			br_reg   <= br_next;
			rv_reg   <= rv_next;
			rr_reg   <= rr_next;
			rdat_reg <= rdat_next;
			sc_reg   <= sc_next;
		end
	end

	assign awready       = !aw_f_reg;
	assign wready        = !w_f_reg;
	assign bvalid        = bv_reg;
	assign bresp         = br_reg;
	assign arready       = !rv_reg;
	assign rvalid        = rv_reg;
	assign rdata         = rdat_reg;
	assign rresp         = rr_reg;
	assign sensor_change = sc_reg;
	assign comp_en       = en_reg;
	assign comp_cap_en   = cap_reg;
	assign speed_out     = spd_reg;

	// ----------------------------------------------------------------
	// Transducer input and scaling
	// ----------------------------------------------------------------
	// Code bits may skew at the pins; a word is taken only once two synchronised samples agree
	logic [ssc_pkg::ADC_W-1:0] adc_s1_reg, adc_s2_reg, adc_s3_reg, adc_ok_reg, adc_ok_next;
	logic signed [ssc_pkg::ADC_W:0] adc_d;
	logic signed [47:0] prod;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adc_s1_reg <= '0;
			adc_s2_reg <= '0;
			adc_s3_reg <= '0;
			adc_ok_reg <= '0;
		end else if (ce) begin
			adc_s1_reg <= adc_code;
			adc_s2_reg <= adc_s1_reg;
			adc_s3_reg <= adc_s2_reg;
			adc_ok_reg <= adc_ok_next;
		end
	end

	always_comb begin
		adc_ok_next = (adc_s2_reg == adc_s3_reg) ? adc_s2_reg : adc_ok_reg;
		adc_d       = $signed({1'b0, adc_ok_reg}) - $signed({1'b0, cfg_reg.volt ? ssc_pkg::ADC_ZERO_VOL
			: ssc_pkg::ADC_ZERO_CUR});
		if (adc_d < 0)
			adc_d = '0;
		prod = 48'(adc_d * (48'(cfg_reg.pmax) - 48'(cfg_reg.pmin))
			* $signed({1'b0, cfg_reg.volt ? ssc_pkg::SCALE_K_VOL : ssc_pkg::SCALE_K_CUR}));
		press_now = ssc_pkg::P_W'(cfg_reg.pmin + (prod >>> ssc_pkg::SCALE_SH));
	end

	// ----------------------------------------------------------------
	// Cycle timer and run-time bookkeeping
	// ----------------------------------------------------------------
	logic [31:0] cyc_reg, cyc_next;
	logic tick;
	logic [ssc_pkg::RT_W-1:0] rt_reg [NC];
	logic [ssc_pkg::RT_W-1:0] rt_next [NC];

	always_comb begin
		tick     = cyc_reg == 32'(CYCLE_CLKS - 1);
		cyc_next = tick ? 32'h0000_0000 : cyc_reg + 32'h0000_0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cyc_reg <= '0;
		else if (ce)
			cyc_reg <= cyc_next;
	end

	for (genvar g = 0; g < NC; g++) begin : g_rt
		always_comb begin
			rt_next[g] = rt_reg[g];
			if (tick && en_reg[g] && rt_reg[g] != '1)
				rt_next[g] = rt_reg[g] + 1'b1;
		end
		always_ff @(posedge aclk) begin
			if (!aresetn)
				rt_reg[g] <= '0;
			else if (ce)
				rt_reg[g] <= rt_next[g];
		end
	end

	// Pick the unit to add or drop; rotation-capable units sort behind the rest
	logic [$clog2(NC)-1:0] on_idx, off_idx;
	logic have_on, have_off;
	logic [ssc_pkg::RT_W:0] on_key, off_key;

	always_comb begin
		on_idx   = '0;
		off_idx  = '0;
		have_on  = 1'b0;
		have_off = 1'b0;
		on_key   = '0;
		off_key  = '1;
		for (int i = 0; i < NC; i++) begin
			if (i != 0 || !cfg_reg.comb) begin
				if (en_reg[i] && (!have_on || {cfg_reg.rot[i], rt_reg[i]} > on_key)) begin
					have_on = 1'b1;
					on_key  = {cfg_reg.rot[i], rt_reg[i]};
					on_idx  = ($clog2(NC))'(i);
				end
				if (!en_reg[i] && (!have_off || {cfg_reg.rot[i], rt_reg[i]} < off_key)) begin
					have_off = 1'b1;
					off_key  = {cfg_reg.rot[i], rt_reg[i]};
					off_idx  = ($clog2(NC))'(i);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Control loop
	// ----------------------------------------------------------------
	ssc_pkg::ssc_state_t st_reg, st_next;
	logic [15:0] blt_reg, blt_next;
	logic signed [EW-1:0] e, nz, b15, hb, di, inew, pi, tgt, i_reg, i_next;
	logic falling, rising, part;

	always_comb begin
		press_next = press_reg;
		err_next   = err_reg;
		en_next    = en_reg;
		spd_next   = spd_reg;
		i_next     = i_reg;
		st_next    = st_reg;
		blt_next   = blt_reg;
		e       = EW'(press_now) - EW'(cfg_reg.setp);
		nz      = EW'(cfg_reg.nz);
		b15     = nz + (nz >>> 1);
		falling = press_now < press_reg;
		rising  = press_now > press_reg;
		part    = en_reg == NC'(1) && spd_reg < ssc_pkg::SPD_HALF && e < nz;
		hb      = part ? nz : (nz >>> 1);
		di      = (part ? e + EW'(cfg_reg.adj) : e) >>> 3;
		if (di > $signed(EW'(ssc_pkg::SPD_I_MAX)))
			di = EW'(ssc_pkg::SPD_I_MAX);
		inew = ((e > 0 && falling && e < hb) || (e < 0 && rising && e > -hb)) ? i_reg : i_reg + di;
		if (inew < 0)
			inew = '0;
		if (inew > EW'(ssc_pkg::SPD_FULL))
			inew = EW'(ssc_pkg::SPD_FULL);
		pi = (e >>> 2) + inew;
		if (e > b15)
			tgt = EW'(ssc_pkg::SPD_FULL);
		else if (e < -b15)
			tgt = EW'(cfg_reg.min_spd);
		else
			tgt = pi;
		// Signed compares: a negative P plus I must land on the floor, not wrap to full speed
		if (tgt < $signed(EW'(cfg_reg.min_spd)))
			tgt = EW'(cfg_reg.min_spd);
		if (tgt > $signed(EW'(ssc_pkg::SPD_FULL)))
			tgt = EW'(ssc_pkg::SPD_FULL);
		if (tick) begin
			press_next = press_now;
			err_next   = e;
			if (!cfg_reg.comb) begin
				st_next = ssc_pkg::ST_IDLE;
				spd_next = '0;
				i_next   = '0;
				if (e > b15 || (e > nz && !falling)) begin
					if (have_off)
						en_next[off_idx] = 1'b1;
				end else if (e < -nz) begin
					if (have_on)
						en_next[on_idx] = 1'b0;
				end
			end else begin
				case (st_reg)
					ssc_pkg::ST_IDLE: begin
						spd_next = '0;
						i_next   = '0;
						en_next  = '0;
						if (e > 0) begin
							en_next[0] = 1'b1;
							spd_next   = cfg_reg.min_spd;
							blt_next   = cfg_reg.bl_time;
							st_next    = ssc_pkg::ST_START;
						end
					end
					ssc_pkg::ST_START: begin
						spd_next = cfg_reg.min_spd;
						i_next   = EW'(cfg_reg.min_spd);
						if (blt_reg == '0)
							st_next = ssc_pkg::ST_RUN;
						else
							blt_next = blt_reg - 1'b1;
					end
					ssc_pkg::ST_RUN: begin
						i_next = inew;
						if (tgt > EW'(spd_reg) && tgt - EW'(spd_reg) > EW'(ssc_pkg::SPD_RAMP))
							spd_next = spd_reg + ssc_pkg::SPD_RAMP;
						else
							spd_next = SW'(tgt);
						if (spd_reg == ssc_pkg::SPD_FULL && e > nz && have_off) begin
							en_next[off_idx] = 1'b1;
							spd_next = spd_reg - ssc_pkg::SPD_COMP;
							i_next   = EW'(spd_reg - ssc_pkg::SPD_COMP);
						end else if (spd_reg <= cfg_reg.min_spd && e < -nz) begin
							if (have_on) begin
								en_next[on_idx] = 1'b0;
								spd_next = spd_reg + ssc_pkg::SPD_COMP;
								i_next   = EW'(spd_reg + ssc_pkg::SPD_COMP);
							end else begin
								en_next  = '0;
								spd_next = '0;
								st_next  = ssc_pkg::ST_IDLE;
							end
						end
					end
					default: st_next = ssc_pkg::ST_IDLE;
				endcase
			end
		end
		cap_next = en_next;
		if (cfg_reg.cap && cfg_reg.comb)
			cap_next[0] = en_next[0] && spd_next >= ssc_pkg::SPD_HALF;
		freq_next = ssc_pkg::FREQ_LOW_HZ + 8'((18'(spd_next) * 18'(ssc_pkg::FREQ_HIGH_HZ
			- ssc_pkg::FREQ_LOW_HZ)) / 18'(ssc_pkg::SPD_FULL));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			press_reg <= '0;
			err_reg   <= '0;
			en_reg    <= '0;
			cap_reg   <= '0;
			spd_reg   <= '0;
			freq_reg  <= ssc_pkg::FREQ_LOW_HZ;
			i_reg     <= '0;
			st_reg    <= ssc_pkg::ST_IDLE;
			blt_reg   <= '0;
		end else if (ce) begin
			press_reg <= press_next;
			err_reg   <= err_next;
			en_reg    <= en_next;
			cap_reg   <= cap_next;
			spd_reg   <= spd_next;
			freq_reg  <= freq_next;
			i_reg     <= i_next;
			st_reg    <= st_next;
			blt_reg   <= blt_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_change_on_tick;
		$changed(en_reg) |-> $past(tick && ce);
	endproperty
	a_change_on_tick: assert property (p_change_on_tick) else $error("stage changed off cycle");

	property p_sens_evt;
		ce && wr_fire && wa_reg == ssc_pkg::OFF_PMIN && wval[15:0] != cfg_reg.pmin |=> sc_reg;
	endproperty
	a_sens_evt: assert property (p_sens_evt) else $error("sensor change not flagged");

	property p_step_nz;
		ce && tick && !cfg_reg.comb && e <= nz && e >= -nz |=> $stable(en_reg);
	endproperty
	a_step_nz: assert property (p_step_nz) else $error("stage moved in neutral zone");

	property p_step_up;
		ce && tick && !cfg_reg.comb && e > b15 && have_off |=> $countones(en_reg) == $countones($past(en_reg)) + 1;
	endproperty
	a_step_up: assert property (p_step_up) else $error("no step up");

	property p_step_hold;
		ce && tick && !cfg_reg.comb && e > nz && e <= b15 && falling |=> $stable(en_reg);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("stage moved while falling");

	property p_step_dn;
		ce && tick && !cfg_reg.comb && e < -nz && have_on |=> $countones(en_reg) == $countones($past(en_reg)) - 1;
	endproperty
	a_step_dn: assert property (p_step_dn) else $error("no step down");

	property p_ramp;
		// A cut-out lifts speed in one step to make up the lost capacity
		spd_reg > $past(spd_reg) && st_reg == ssc_pkg::ST_RUN && $countones(en_reg) >= $countones($past(en_reg))
			|-> spd_reg - $past(spd_reg) <= ssc_pkg::SPD_RAMP;
	endproperty
	a_ramp: assert property (p_ramp) else $error("speed rose too fast");

	property p_start;
		ce && tick && cfg_reg.comb && st_reg == ssc_pkg::ST_IDLE && e > 0
			|=> en_reg[0] && spd_reg == cfg_reg.min_spd;
	endproperty
	a_start: assert property (p_start) else $error("first stage start wrong");

	property p_fixed_cap;
		cfg_reg.cap |-> cap_reg[NC-1:1] == en_reg[NC-1:1];
	endproperty
	a_fixed_cap: assert property (p_fixed_cap) else $error("fixed unit stages split");

	c_step_up: cover property (ce && tick && !cfg_reg.comb && e > b15);
	c_run: cover property (st_reg == ssc_pkg::ST_START ##1 st_reg == ssc_pkg::ST_RUN);
	c_cut_in: cover property (st_reg == ssc_pkg::ST_RUN && $rose(|en_reg[NC-1:1]));
endmodule

/* bench/ssc_plant.sv */
module ssc_plant (
	input  wire logic        aclk,     // Clock
	input  wire logic [11:0] code_set, // Wanted transducer level
	output logic      [11:0] adc_code  // Converter code seen by the controller
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sampled front end: the code moves once per clock, never mid-cycle
	always_ff @(posedge aclk) begin
		adc_code <= code_set;
	end
endmodule

/* bench/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC   = 40;
	localparam int NZ    = 32'h40;
	localparam int MINSP = 32'h100;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, sensor_change;
	logic [7:0]  awaddr, araddr, comp_en, comp_cap_en;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [11:0] code_set, adc_code;
	logic [9:0]  speed_out;
	int          num_errors, tests_run, seed, k, n, e, c, x;
	ssc_plant pm (.aclk(aclk), .code_set(code_set), .adc_code(adc_code));
	ssc_ctrl #(.CYCLE_CLKS(CYC)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .adc_code(adc_code), .comp_en(comp_en),
		.comp_cap_en(comp_cap_en), .speed_out(speed_out), .sensor_change(sensor_change));
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Ready and valid read right after the edge are still the pre-edge values
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rs = bresp;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		v = rdata;
		rs = rresp;
		@(posedge aclk);
	endtask
	// Outputs move only on a cycle tick; wait for the next move, bounded
	task automatic wait_out();
		logic [17:0] o;
		o = {comp_en, speed_out};
		for (int w = 0; w < 4 * CYC && {comp_en, speed_out} == o; w++) @(negedge aclk);
		@(posedge aclk);
	endtask
	function automatic int pick(input int i);
		int u;
		u = $unsigned($random(seed)) % 256;
		if (i == 0) return 16'h61;
		if (i < 3) return 16'h61 + u;
		if (i < 5) return u % 127 - 63;
		return -16'h41 - u;
	endfunction
	function automatic int exp_cnt(input int cnt, input int err);
		if (err > NZ + NZ / 2) return cnt + 1;
		if (err < -NZ && cnt > 0) return cnt - 1;
		return cnt;
	endfunction
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		repeat (60 * CYC) @(posedge aclk);
		num_errors++;
		close_out();
	end
	initial begin
		seed = 32'he6869185;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		code_set = 12'h800;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ssc_pkg::OFF_STAT, d, r);
		check("status at reset", d, 32'h0);
		wr(ssc_pkg::OFF_PMAX, 32'h1000, r);
		rd(ssc_pkg::OFF_STAT, d, r);
		check("status after max", d, 32'h1);
		wr(ssc_pkg::OFF_STAT, 32'h1, r);
		rd(ssc_pkg::OFF_STAT, d, r);
		check("status cleared", d, 32'h0);
		wr(ssc_pkg::OFF_CTRL, 32'h2, r);
		check("event port", {31'h0, sensor_change}, 32'h1);
		wr(ssc_pkg::OFF_PRESS, 32'h5, r);
		check("ro write resp", {30'h0, r}, {30'h0, ssc_pkg::RESP_SLVERR});
		rd(8'h3c, d, r);
		check("unmapped read resp", {30'h0, r}, {30'h0, ssc_pkg::RESP_SLVERR});
		wr(ssc_pkg::OFF_SETP, 32'h800, r);
		wr(ssc_pkg::OFF_NZ, 32'(NZ), r);
		// Up three stages, sit inside the zone, then down three
		c = 0;
		for (k = 0; k < 8; k++) begin
			e = pick(k);
			code_set <= 12'(2048 + e);
			n = c;
			c = exp_cnt(c, e);
			for (int w = 0; w < 2 * CYC + 4 && $countones(comp_en) == n; w++) @(negedge aclk);
			@(posedge aclk);
			check("stage count", 32'($countones(comp_en)), 32'(c));
			rd(ssc_pkg::OFF_ERR, d, r);
			check("error", d, 32'(e));
			rd(ssc_pkg::OFF_PRESS, d, r);
			check("pressure", d, 32'(2048 + e));
		end
		// Combined mode: start at minimum speed, ramp up, cut a fixed unit in and out again
		wr(ssc_pkg::OFF_MINSP, 32'(MINSP), r);
		wr(ssc_pkg::OFF_BLT, 32'h1, r);
		wr(ssc_pkg::OFF_CTRL, 32'h7, r);
		code_set <= 12'(2048 + 3 * NZ);
		wait_out();
		check("start stages", 32'(comp_en), 32'h1);
		check("start speed", 32'(speed_out), 32'(MINSP));
		x = MINSP;
		for (k = 0; k < 4; k++) begin
			wait_out();
			x = x + int'(ssc_pkg::SPD_RAMP);
			if (x > int'(ssc_pkg::SPD_FULL)) x = int'(ssc_pkg::SPD_FULL);
			check("ramp speed", 32'(speed_out), 32'(x));
		end
		check("cap at full", 32'(comp_cap_en), 32'h1);
		rd(ssc_pkg::OFF_SPEED, d, r);
		check("freq at full", 32'(d[23:16]), 32'(ssc_pkg::FREQ_HIGH_HZ));
		wait_out();
		check("cut in", 32'($countones(comp_en)), 32'h2);
		check("cut in speed", 32'(speed_out), 32'(ssc_pkg::SPD_FULL - ssc_pkg::SPD_COMP));
		check("fixed cap", 32'(comp_cap_en), 32'(comp_en & 8'hfe));
		code_set <= 12'(2048 - 3 * NZ);
		wait_out();
		check("drop to min", 32'(speed_out), 32'(MINSP));
		wait_out();
		check("cut out", 32'($countones(comp_en)), 32'h1);
		check("cut out speed", 32'(speed_out), 32'(MINSP + int'(ssc_pkg::SPD_COMP)));
		wait_out();
		wait_out();
		check("all off", 32'({comp_en, speed_out}), 32'h0);
		wr(ssc_pkg::OFF_STAT, 32'h1, r);
		check("event cleared", {31'h0, sensor_change}, 32'h0);
		wr(ssc_pkg::OFF_PMIN, 32'h10, r);
		check("event on min", {31'h0, sensor_change}, 32'h1);
		wr(ssc_pkg::OFF_PMIN, 32'h0, r);
		close_out();
	end
endmodule
